// ---- hw/swcp_host.sv ----
/*
  Host controller for the single-wire configuration port. Software orders one
  transaction at a time through a small register port; the block runs reset,
  presence, the 8-bit command and the 9 data bits on the open-drain line.
  Assumes an external pull-up on the line and inputs synchronous to ref_clk.
*/
`timescale 1ns/1ps
module swcp_host
#(
  parameter int unsigned CW   = 18,
  parameter int unsigned RSTL = swcp_pkg::C_RSTL,
  parameter int unsigned RSTH = swcp_pkg::C_RSTH,
  parameter int unsigned PDS  = swcp_pkg::C_PDS,
  parameter int unsigned LOW0 = swcp_pkg::C_LOW0,
  parameter int unsigned LOW1 = swcp_pkg::C_LOW1,
  parameter int unsigned RDS  = swcp_pkg::C_RDS,
  parameter int unsigned SLOT = swcp_pkg::C_SLOT,
  parameter int unsigned REC  = swcp_pkg::C_REC
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // software register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // device power and strap
  output logic             dev_power,
  output logic             prog_pullup,
  // open-drain data line
  input  wire logic        dq_in,
  output logic             dq_out,
  output logic             dq_oe
);
  import swcp_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  typedef enum logic [1:0] {S_IDLE, S_RST, S_CMD, S_DATA} swcp_state_t;

  swcp_state_t                         state;
  swcp_op_t                            op_q;
  logic [3:0]                          bitcnt;
  logic [DATA_BITS-1:0]                tx_data;
  logic                                done_flag;
  logic                                pres_flag;
  logic                                nopres_flag;
  logic                                go_acc;
  logic                                clr_done;
  logic                                clr_nopres;
  logic                                slot_start;
  swcp_slot_t                          slot_kind;
  logic                                slot_busy;
  logic                                slot_done;
  logic                                slot_bit;
  logic                                tx_load;
  logic                                tx_shift;
  logic                                rx_shift;
  logic [CMD_BITS+DATA_BITS-1:0]       tx_q;
  logic [DATA_BITS-1:0]                rx_q;
  logic                                step;
  logic                                rd_mode;

  // ****************************************************
  // register writes
  // ****************************************************

  // a go while a transaction runs is ignored, so one register per run
  assign go_acc     = ce && wr && addr == OFS_CTRL && wdata[CTRL_GO] && state == S_IDLE;
  assign clr_done   = ce && wr && addr == OFS_STATUS && wdata[ST_DONE];
  assign clr_nopres = ce && wr && addr == OFS_STATUS && wdata[ST_NOPRES];

  // operation latch, only taken with an accepted go
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= OP_WR_DIV;
    end else if (go_acc) begin
      op_q <= swcp_op_t'(wdata[CTRL_OP+1:CTRL_OP]);
    end
  end

  // device power and programming strap; both off after reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_power   <= 1'b0;
      prog_pullup <= 1'b0;
    end else if (ce && wr && addr == OFS_CTRL) begin
      dev_power   <= wdata[CTRL_PWR];
      prog_pullup <= wdata[CTRL_PULL];
    end
  end

  // word to send; held by software between runs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data <= DIV_DEFAULT;
    end else if (ce && wr && addr == OFS_TXDATA) begin
      tx_data <= wdata[DATA_BITS-1:0];
    end
  end

  // ****************************************************
  // transaction sequencer
  // ****************************************************

  assign rd_mode = swcp_is_read(op_q);
  assign step    = ce && slot_done;

  // reset first, then command, then data, then back to idle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
    end else if (go_acc) begin
      state <= S_RST;
    end else if (step) begin
      case (state)
        S_RST: begin
          // no presence seen: give up instead of talking to nobody
          state <= slot_bit ? S_IDLE : S_CMD;
        end
        S_CMD: begin
          if (bitcnt == 4'(CMD_BITS - 1)) begin
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (bitcnt == 4'(DATA_BITS - 1)) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // bit counter within command and data phases
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitcnt <= 4'h0;
    end else if (go_acc) begin
      bitcnt <= 4'h0;
    end else if (step && state == S_CMD) begin
      bitcnt <= (bitcnt == 4'(CMD_BITS - 1)) ? 4'h0 : bitcnt + 4'h1;
    end else if (step && state == S_DATA) begin
      bitcnt <= bitcnt + 4'h1;
    end
  end

  // ****************************************************
  // status flags
  // ****************************************************

  // done: set on end of data or on missing presence; set beats clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_flag <= 1'b0;
    end else if (step && state == S_DATA && bitcnt == 4'(DATA_BITS - 1)) begin
      done_flag <= 1'b1;
    end else if (step && state == S_RST && slot_bit) begin
      done_flag <= 1'b1;
    end else if (clr_done) begin
      done_flag <= 1'b0;
    end
  end

  // missing-presence error, sticky, set beats clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nopres_flag <= 1'b0;
    end else if (step && state == S_RST && slot_bit) begin
      nopres_flag <= 1'b1;
    end else if (clr_nopres) begin
      nopres_flag <= 1'b0;
    end
  end

  // presence of the last reset, a level refreshed every run
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pres_flag <= 1'b0;
    end else if (step && state == S_RST) begin
      pres_flag <= !slot_bit;
    end
  end

  // ****************************************************
  // slot requests and shift paths
  // ****************************************************

  // a new slot follows the previous one as soon as it has ended
  assign slot_start = state != S_IDLE && !slot_busy;

  // slot kind from phase and next outgoing bit, lsb first
  always_comb begin
    case (state)
      S_RST:   slot_kind = SK_RESET;
      S_CMD:   slot_kind = tx_q[0] ? SK_WR1 : SK_WR0;
      S_DATA:  slot_kind = rd_mode ? SK_READ : (tx_q[0] ? SK_WR1 : SK_WR0);
      default: slot_kind = SK_RESET;
    endcase
  end

  // command sits below the data word; both leave lsb first
  assign tx_load  = go_acc;
  assign tx_shift = step && (state == S_CMD || (state == S_DATA && !rd_mode));
  assign rx_shift = step && state == S_DATA && rd_mode;

  swcp_shift #(
    .W (CMD_BITS + DATA_BITS)
  ) u_tx (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .load     (tx_load),
    .load_val ({tx_data, swcp_opcode(swcp_op_t'(wdata[CTRL_OP+1:CTRL_OP]))}),
    .shift    (tx_shift),
    .in_bit   (1'b1),
    .q        (tx_q)
  );

  // read bits enter at the top so the word lands in place after nine
  swcp_shift #(
    .W (DATA_BITS)
  ) u_rx (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .load     (1'b0),
    .load_val ('0),
    .shift    (rx_shift),
    .in_bit   (slot_bit),
    .q        (rx_q)
  );

  swcp_slot #(
    .CW   (CW),
    .RSTL (RSTL),
    .RSTH (RSTH),
    .PDS  (PDS),
    .LOW0 (LOW0),
    .LOW1 (LOW1),
    .RDS  (RDS),
    .SLOT (SLOT),
    .REC  (REC)
  ) u_slot (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .start   (slot_start),
    .kind    (slot_kind),
    .busy    (slot_busy),
    .done    (slot_done),
    .bit_q   (slot_bit),
    .dq_in   (dq_in),
    .dq_oe   (dq_oe)
  );

  // open drain: only ever pull low
  assign dq_out = 1'b0;

  // ****************************************************
  // register reads
  // ****************************************************

  // data only in the cycle after the strobe, zero after other cycles with ce high, held while ce is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          OFS_CTRL:   rdata <= {27'h0, prog_pullup, dev_power, op_q, 1'b0};
          OFS_TXDATA: rdata <= {23'h0, tx_data};
          OFS_STATUS: rdata <= {28'h0, nopres_flag, pres_flag, done_flag, state != S_IDLE};
          OFS_RXDATA: rdata <= {23'h0, rx_q};
          default:    rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_RESET_FIRST: assert property (go_acc |=> state == S_RST && dq_oe == 1'b0 ##1 dq_oe)
    else $error("transaction did not open with a reset pulse");
  AST_NO_PRESENCE: assert property (step && state == S_RST && slot_bit |=> state == S_IDLE && nopres_flag)
    else $error("missing presence not reported");
  AST_CMD_EIGHT: assert property (step && state == S_CMD && bitcnt == 4'h7 |=> state == S_DATA && bitcnt == 4'h0)
    else $error("command phase not eight bits");
  AST_OPCODE: assert property (go_acc |=> tx_q[7:0] == swcp_opcode(op_q) && tx_q[16:8] == tx_data)
    else $error("wrong command code loaded");
  AST_DATA_NINE: assert property (step && state == S_DATA && bitcnt == 4'h8 |=> state == S_IDLE && done_flag)
    else $error("data phase not nine bits");
  AST_ONE_PER_RUN: assert property (state != S_IDLE |=> $stable(op_q))
    else $error("operation changed during a transaction");
  AST_DONE_SET_WINS: assert property (step && state == S_DATA && bitcnt == 4'h8 && clr_done |=> done_flag)
    else $error("done lost to a clear");
  AST_LINE_IDLE: assert property (state == S_IDLE && !slot_busy |-> !dq_oe)
    else $error("line driven outside a slot");

  COV_WRITE_RUN: cover property (step && state == S_DATA && bitcnt == 4'h8 && !rd_mode);
  COV_READ_RUN: cover property (step && state == S_DATA && bitcnt == 4'h8 && rd_mode);
  COV_NO_PRESENCE: cover property (step && state == S_RST && slot_bit);
endmodule : swcp_host

// ---- hw/swcp_pkg.sv ----
/*
  Shared constants for the single-wire configuration port host: slot timing,
  function command codes, software register map and field positions.
  Assumes a 200 MHz ref_clk; every cycle count is derived from the time in ns.
*/
package swcp_pkg;

  // ****************************************************
  // timing, in ns, and derived cycle counts
  // ****************************************************
  localparam int CLK_NS    = 5;
  localparam int T_RSTL_NS = 480000;  // reset low, least
  localparam int T_RSTH_NS = 480000;  // reset release window, least
  localparam int T_PDS_NS  = 70000;   // presence sample after release, longest
  localparam int T_LOW0_NS = 60000;   // write zero low time, least
  localparam int T_LOW1_NS = 6000;    // write one / read low time, least
  localparam int T_RDS_NS  = 15000;   // read sample from slot start, longest
  localparam int T_SLOT_NS = 70000;   // whole slot, least
  localparam int T_REC_NS  = 10000;   // recovery between slots, least
  localparam int C_RSTL = (T_RSTL_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RSTH = (T_RSTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_PDS  = T_PDS_NS / CLK_NS;
  localparam int C_LOW0 = (T_LOW0_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_LOW1 = (T_LOW1_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RDS  = T_RDS_NS / CLK_NS;
  localparam int C_SLOT = (T_SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_REC  = (T_REC_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************
  // link framing and device values
  // ****************************************************
  localparam int CMD_BITS  = 8;
  localparam int DATA_BITS = 9;
  localparam logic [7:0] CMD_WR_DIV = 8'h01;
  localparam logic [7:0] CMD_RD_DIV = 8'hA1;
  localparam logic [7:0] CMD_WR_MUX = 8'h02;
  localparam logic [7:0] CMD_RD_MUX = 8'hA2;
  localparam logic [8:0] DIV_DEFAULT = 9'h000;
  localparam logic [8:0] MUX_DEFAULT = 9'h034;

  // ****************************************************
  // software register map
  // ****************************************************
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_TXDATA = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_RXDATA = 4'hC;
  localparam int CTRL_GO   = 0;
  localparam int CTRL_OP   = 1;  // two bits
  localparam int CTRL_PWR  = 3;
  localparam int CTRL_PULL = 4;
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_PRES   = 2;
  localparam int ST_NOPRES = 3;

  typedef enum logic [1:0] {OP_WR_DIV, OP_RD_DIV, OP_WR_MUX, OP_RD_MUX} swcp_op_t;
  typedef enum logic [1:0] {SK_RESET, SK_WR0, SK_WR1, SK_READ} swcp_slot_t;

  // command code for an operation
  function automatic logic [7:0] swcp_opcode(input swcp_op_t op);
    case (op)
      OP_WR_DIV: swcp_opcode = CMD_WR_DIV;
      OP_RD_DIV: swcp_opcode = CMD_RD_DIV;
      OP_WR_MUX: swcp_opcode = CMD_WR_MUX;
      default:   swcp_opcode = CMD_RD_MUX;
    endcase
  endfunction : swcp_opcode

  // read operations take data from the device
  function automatic logic swcp_is_read(input swcp_op_t op);
    swcp_is_read = (op == OP_RD_DIV) || (op == OP_RD_MUX);
  endfunction : swcp_is_read

endpackage : swcp_pkg

// ---- hw/swcp_shift.sv ----
/*
  Parallel-load shift register, shifting toward bit 0 with entry at the top.
  Assumes the caller never loads and shifts in the same cycle.
*/
`timescale 1ns/1ps
module swcp_shift #(
  parameter int W = 9
) (
  // clock, reset, enable
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // control and data
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         shift,
  input  wire logic         in_bit,
  output logic      [W-1:0] q
);
  genvar i;

  // one flop per bit; bit 0 is the next to leave, lsb first
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          q[i] <= 1'b0;
        end else if (ce && load) begin
          q[i] <= load_val[i];
        end else if (ce && shift) begin
          q[i] <= (i == W - 1) ? in_bit : q[(i + 1) % W];
        end
      end
    end
  endgenerate
endmodule : swcp_shift

// ---- hw/swcp_slot.sv ----
/*
  One link slot: reset/presence, write zero, write one or read.
  Drives the open-drain line low only; assumes an external pull-up.
*/
`timescale 1ns/1ps
module swcp_slot
#(
  parameter int unsigned CW   = 18,
  parameter int unsigned RSTL = swcp_pkg::C_RSTL,
  parameter int unsigned RSTH = swcp_pkg::C_RSTH,
  parameter int unsigned PDS  = swcp_pkg::C_PDS,
  parameter int unsigned LOW0 = swcp_pkg::C_LOW0,
  parameter int unsigned LOW1 = swcp_pkg::C_LOW1,
  parameter int unsigned RDS  = swcp_pkg::C_RDS,
  parameter int unsigned SLOT = swcp_pkg::C_SLOT,
  parameter int unsigned REC  = swcp_pkg::C_REC
) (
  // clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  // request and answer
  input  wire logic                 start,
  input  wire swcp_pkg::swcp_slot_t kind,
  output logic                      busy,
  output logic                      done,
  output logic                      bit_q,
  // data line
  input  wire logic                 dq_in,
  output logic                      dq_oe
);
  import swcp_pkg::*;

  swcp_slot_t    kind_q;
  logic [CW-1:0] cnt;
  logic [CW-1:0] low_len;
  logic [CW-1:0] samp_at;
  logic [CW-1:0] last_at;

  // phase boundaries per slot kind
  always_comb begin
    low_len = CW'(LOW1);
    samp_at = CW'(RDS);
    last_at = CW'(SLOT + REC - 1);
    case (kind_q)
      SK_RESET: begin
        low_len = CW'(RSTL);
        samp_at = CW'(RSTL + PDS);
        last_at = CW'(RSTL + RSTH - 1);
      end
      SK_WR0:   low_len = CW'(LOW0);
      SK_WR1:   low_len = CW'(LOW1);
      SK_READ:  low_len = CW'(LOW1);
      default:  low_len = CW'(LOW1);
    endcase
  end

  // slot counter; a start while busy is never issued by the caller
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy   <= 1'b0;
      cnt    <= '0;
      kind_q <= SK_RESET;
    end else if (ce) begin
      if (!busy) begin
        if (start) begin
          busy   <= 1'b1;
          cnt    <= '0;
          kind_q <= kind;
        end
      end else begin
        cnt <= cnt + 1'b1;
        if (cnt == last_at) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // line sample: presence after reset, data in read slots
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_q <= 1'b1;
    end else if (ce && busy && cnt == samp_at) begin
      bit_q <= dq_in;
    end
  end

  // every slot opens low; pulse length sets the bit
  assign dq_oe = busy && (cnt < low_len);
  assign done  = busy && (cnt == last_at);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_SLOT_OPENS_LOW: assert property (start && !busy && ce |=> dq_oe && cnt == '0)
    else $error("slot did not open with the line low");
  AST_ONE_RELEASED: assert property (busy && kind_q == SK_WR1 && cnt == CW'(LOW1) |-> !dq_oe)
    else $error("write one held the line too long");
  AST_RESET_HELD: assert property (busy && kind_q == SK_RESET && cnt == CW'(RSTL - 1) |-> dq_oe)
    else $error("reset pulse released early");
endmodule : swcp_slot

// ---- verif/swcp_dev_model.sv ----
/*
  Behavioural model of the configured device: two 9-bit registers behind a single-wire slave.
  Assumes the line dq is resolved by the bench with a pull-up, sampled on ref_clk.
*/
`timescale 1ns/1ps
module swcp_dev_model #(
  parameter int RST_MIN = 30,
  parameter int SMP     = 12,
  parameter int PRES_W  = 15
) (
  // clock and device pins
  input  wire logic ref_clk,
  input  wire logic powered,
  input  wire logic strap,
  input  wire logic dq,
  output logic      dev_oe = 1'b0
);
  logic [8:0] div_word             = 9'h000;
  logic [8:0] prescaler_mux_config = 9'h034;
  logic [7:0] cmd                  = 8'h00;
  logic [8:0] sh                   = 9'h000;
  logic [7:0] c;
  logic       up = 1'b0, act = 1'b0, dq_d = 1'b1;
  int         lowc = 0, tmr = 0, pres = 0, nbit = 99;
  // delay timer restarts at each slot fall; only a strapped power-up enables the port
  always @(posedge ref_clk) begin
    dq_d <= dq;
    lowc <= dq ? 0 : lowc + 1;
    if (!powered) begin
      up   <= 1'b0;
      act  <= 1'b0;
      pres <= 0;
      tmr  <= 0;
      nbit <= 99;
    end else begin
      up <= 1'b1;
      if (!up) act <= strap;
      if (pres > 0) pres <= pres - 1;
      if (act && dq && !dq_d && lowc >= RST_MIN) begin
        pres <= PRES_W + 3;
        nbit <= 0;
      end
      if (act && !dq && dq_d && pres == 0 && nbit < 17) tmr <= 1;
      else if (tmr == SMP) tmr <= 0;
      else if (tmr > 0) tmr <= tmr + 1;
      if (tmr == SMP) begin
        c = {dq, cmd[7:1]};
        nbit <= nbit + 1;
        if (nbit < 8) cmd <= c;
        if (nbit == 7) sh <= (c == 8'hA1) ? div_word : prescaler_mux_config;
        else if (nbit >= 8) sh <= cmd[7] ? sh >> 1 : {dq, sh[8:1]};
        if (nbit == 16 && cmd == 8'h01) div_word <= {dq, sh[8:1]};
        if (nbit == 16 && cmd == 8'h02) prescaler_mux_config <= {dq, sh[8:1]};
      end
    end
    // presence, and a zero read held low until the timer runs out
    dev_oe <= (pres > 0 && pres <= PRES_W) || (cmd[7] && nbit >= 8 && nbit < 17 && tmr > 0 && tmr < SMP && !sh[0]);
  end
endmodule : swcp_dev_model

// ---- verif/swcp_host_bench.sv ----
/*
  Self-checking bench for the single-wire host: register-port tasks and transaction sequences.
  Assumes the device model above and a pull-up on the resolved line.
*/
`timescale 1ns/1ps
module swcp_host_bench;
  import swcp_pkg::*;
  logic        ref_clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [31:0] wdata   = 32'h0, rdata, v;
  logic        dev_power, prog_pullup, dq_out, dq_oe, dev_oe, dq;
  int          fail_count = 0, checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  assign dq = !((dq_oe && !dq_out) || dev_oe);  // pull-up unless someone pulls low
  // short slot counts keep the run brief; keep LOW1 < RDS < LOW0 < SLOT and PDS < RSTH
  localparam int unsigned B_RSTL = 40, B_RSTH = 40, B_PDS = 10, B_LOW0 = 20;
  localparam int unsigned B_LOW1 = 3, B_RDS = 8, B_SLOT = 30, B_REC = 4;
  swcp_host #(.RSTL(B_RSTL), .RSTH(B_RSTH), .PDS(B_PDS), .LOW0(B_LOW0), .LOW1(B_LOW1), .RDS(B_RDS), .SLOT(B_SLOT),
    .REC(B_REC)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .dev_power(dev_power), .prog_pullup(prog_pullup), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe));
  swcp_dev_model i_dev (.ref_clk(ref_clk), .powered(dev_power), .strap(prog_pullup), .dq(dq), .dev_oe(dev_oe));

  task automatic final_report;
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_read

  // bounded poll for done, compare status, clear the sticky bits
  task automatic wait_done(input logic [31:0] exp);
    v = 32'h0;
    for (int i = 0; i < 2000 && v[1] !== 1'b1; i++) reg_read(OFS_STATUS, v);
    check(v, exp);
    if (v[1] !== 1'b1) final_report();
    else reg_write(OFS_STATUS, 32'hA);
  endtask : wait_done

  task automatic txn(input logic [31:0] ctrl, input logic [31:0] data, input logic [31:0] rx);
    reg_write(OFS_TXDATA, data);
    reg_write(OFS_CTRL, ctrl);
    wait_done(32'h6);
    reg_read(OFS_RXDATA, v);
    if (ctrl[1]) check(v, rx);
  endtask : txn

  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    check({28'h0, dq_out, dq_oe, dev_power, prog_pullup}, 32'h0);
    // every even offset reads zero after reset, unmapped ones included
    for (int a = 0; a < 16; a += 2) begin
      reg_read(a[3:0], v);
      check(v, 32'h0);
    end
    reg_write(OFS_CTRL, 32'h3);
    wait_done(32'hA);
    reg_write(OFS_CTRL, 32'h18);
    txn(32'h1B, 32'h0, 32'h000);
    check({24'h0, i_dev.cmd}, 32'hA1);
    txn(32'h1F, 32'h0, 32'h034);
    check({24'h0, i_dev.cmd}, 32'hA2);
    txn(32'h19, 32'h1A5, 32'h0);
    check({23'h0, i_dev.div_word}, 32'h1A5);
    txn(32'h1D, 32'h0CB, 32'h0);
    check({23'h0, i_dev.prescaler_mux_config}, 32'h0CB);
    txn(32'h1B, 32'h0, 32'h1A5);
    // a second go during the run must be ignored
    reg_write(OFS_CTRL, 32'h1F);
    reg_write(OFS_CTRL, 32'h19);
    wait_done(32'h6);
    reg_read(OFS_RXDATA, v);
    check(v, 32'h0CB);
    check({23'h0, i_dev.div_word}, 32'h1A5);
    reg_read(OFS_CTRL, v);
    check(v, 32'h1E);
    // a strobe while the clock enable is low must change nothing
    @(posedge ref_clk);
    ce <= 1'b0;
    reg_write(OFS_TXDATA, 32'h155);
    ce <= 1'b1;
    reg_read(OFS_TXDATA, v);
    check(v, 32'h0);
    // power cycle without the strap: device stays in normal mode, no presence
    reg_write(OFS_CTRL, 32'h0);
    reg_write(OFS_CTRL, 32'h9);
    wait_done(32'hA);
    check({23'h0, i_dev.div_word}, 32'h1A5);
    final_report();
  end
endmodule : swcp_host_bench
